// >>> rtl/bcr_pkg.sv
// Package with constants and types of the chip rate configuration block.
// Function
// - Bit 2 selects 32 or 64 chips.
// - Bit 1 selects double or normal rate.
// - Rate select only counts with 32-chip codes.
// - Double rate splits code, 62.5 kbits/sec.
// - Normal 32-chip rate is 32 kbits/sec.
// - Bit 0 selects 12x or 6x sampling.
// - 12x only with 32 chips, normal rate.
// - Half select picks upper or lower word only with 32 chips, normal rate.
package bcr_pkg;
    localparam logic [7:0] RATE_CFG_OFFSET = 8'h04;
    localparam logic [7:0] RATE_CFG_RESET = 8'h00;
    localparam int CODE_WIDTH_BIT = 2;
    localparam int DATA_RATE_BIT = 1;
    localparam int SAMPLE_RATE_BIT = 0;
    localparam int RESERVED_LSB = 3;
    localparam int HALF_CHIPS = 32;
    // Raw throughput in tenths of a kilobit per second.
    localparam logic [9:0] RATE_DOUBLE_X10 = 10'h271;
    localparam logic [9:0] RATE_NORMAL32_X10 = 10'h140;
    localparam logic [9:0] RATE_CHIPS64_X10 = 10'h0a0;

    typedef struct packed {
        logic chips32;
        logic double_rate;
        logic sample12;
    } bcr_cfg_t;

    typedef struct packed {
        logic chips32;
        logic double_rate;
        logic sample12;
        logic [1:0] bits_per_code;
        logic [9:0] rate_x10;
    } bcr_mode_t;
endpackage : bcr_pkg

// >>> rtl/bcr_code_split.sv
// Splitter that hands the correlators their two 32-chip code words.
`timescale 1ns/10ps
`default_nettype none
module bcr_code_split (
    input wire bcr_pkg::bcr_mode_t mode_in,
    input wire logic half_sel_in,
    input wire logic [63:0] pn_code_in,
    output logic [31:0] code_a_out,
    output logic [31:0] code_b_out
);
    logic [31:0] upper;
    logic [31:0] lower;

    assign upper = pn_code_in[63:bcr_pkg::HALF_CHIPS];
    assign lower = pn_code_in[bcr_pkg::HALF_CHIPS-1:0];

    always_comb begin
        if (mode_in.chips32 && !mode_in.double_rate) begin
            // Word A is the chosen half; word B is the second code.
            code_a_out = half_sel_in ? upper : lower;
            code_b_out = half_sel_in ? lower : upper;
        end else begin
            // Both halves in use: one bit per half in double rate.
            code_a_out = lower;
            code_b_out = upper;
        end
    end
endmodule : bcr_code_split
`default_nettype wire

// >>> rtl/bcr_rate_cfg.sv
// Chip rate configuration register with decoded baseband mode outputs.
`timescale 1ns/10ps
`default_nettype none
module bcr_rate_cfg (
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic WR_STB_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic RD_STB_IN,
    input wire logic CODE_HALF_SEL_IN,
    input wire logic [63:0] PN_CODE_IN,
    output logic [7:0] RDATA_OUT,
    output logic RD_VALID_OUT,
    output logic CHIPS32_OUT,
    output logic DOUBLE_RATE_OUT,
    output logic SAMPLE12_OUT,
    output logic [1:0] BITS_PER_CODE_OUT,
    output logic [9:0] RATE_X10_OUT,
    output logic [31:0] CODE_A_OUT,
    output logic [31:0] CODE_B_OUT
);
    typedef struct packed {
        bcr_pkg::bcr_cfg_t cfg;
        bcr_pkg::bcr_mode_t mode;
        logic [7:0] rdata;
        logic rd_valid;
        logic [31:0] code_a;
        logic [31:0] code_b;
    } bcr_state_t;

    bcr_state_t st_q;
    bcr_state_t st_d;
    bcr_pkg::bcr_mode_t mode_now;
    logic [31:0] split_a;
    logic [31:0] split_b;
    logic hit;

    function automatic bcr_pkg::bcr_mode_t decode(bcr_pkg::bcr_cfg_t c);
        bcr_pkg::bcr_mode_t m;
        m.chips32 = c.chips32;
        m.double_rate = c.chips32 & c.double_rate;
        m.sample12 = c.chips32 & ~c.double_rate & c.sample12;
        m.bits_per_code = m.double_rate ? 2'h2 : 2'h1;
        if (m.double_rate) begin
            m.rate_x10 = bcr_pkg::RATE_DOUBLE_X10;
        end else if (m.chips32) begin
            m.rate_x10 = bcr_pkg::RATE_NORMAL32_X10;
        end else begin
            m.rate_x10 = bcr_pkg::RATE_CHIPS64_X10;
        end
        return m;
    endfunction : decode

    assign hit = (ADDR_IN == bcr_pkg::RATE_CFG_OFFSET);
    assign mode_now = decode(st_q.cfg);

    bcr_code_split u_split (
        .mode_in(mode_now),
        .half_sel_in(CODE_HALF_SEL_IN),
        .pn_code_in(PN_CODE_IN),
        .code_a_out(split_a),
        .code_b_out(split_b)
    );

    always_comb begin
        st_d = st_q;
        st_d.rd_valid = 1'b0;
        if (WR_STB_IN && hit) begin
            // Reserved bits are expected as zero and are not stored.
            st_d.cfg.chips32 = WDATA_IN[bcr_pkg::CODE_WIDTH_BIT];
            st_d.cfg.double_rate = WDATA_IN[bcr_pkg::DATA_RATE_BIT];
            st_d.cfg.sample12 = WDATA_IN[bcr_pkg::SAMPLE_RATE_BIT];
        end
        if (RD_STB_IN && hit) begin
            st_d.rdata = 8'h00;
            st_d.rdata[bcr_pkg::CODE_WIDTH_BIT] = st_q.cfg.chips32;
            st_d.rdata[bcr_pkg::DATA_RATE_BIT] = st_q.cfg.double_rate;
            st_d.rdata[bcr_pkg::SAMPLE_RATE_BIT] = st_q.cfg.sample12;
            st_d.rd_valid = 1'b1;
        end
        st_d.mode = mode_now;
        st_d.code_a = split_a;
        st_d.code_b = split_b;
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign RDATA_OUT = st_q.rdata;
    assign RD_VALID_OUT = st_q.rd_valid;
    assign CHIPS32_OUT = st_q.mode.chips32;
    assign DOUBLE_RATE_OUT = st_q.mode.double_rate;
    assign SAMPLE12_OUT = st_q.mode.sample12;
    assign BITS_PER_CODE_OUT = st_q.mode.bits_per_code;
    assign RATE_X10_OUT = st_q.mode.rate_x10;
    assign CODE_A_OUT = st_q.code_a;
    assign CODE_B_OUT = st_q.code_b;

    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (RST_IN);

    sequence s_write(logic [7:0] d);
        WR_STB_IN && hit && WDATA_IN == d;
    endsequence

    sequence s_read;
        RD_STB_IN && hit;
    endsequence

    a_width_select: assert property (
        s_write(8'h04) |-> ##2 CHIPS32_OUT)
        else $error("32-chip width not applied two cycles after write");

    a_rate_honoured: assert property (
        s_write(8'h06) |-> ##2 (DOUBLE_RATE_OUT && BITS_PER_CODE_OUT == 2'h2))
        else $error("double rate not applied after write");

    // Mode outputs hold zero for one edge after reset before the decode.
    a_rate_ignored: assert property (
        !$past(RST_IN) && !CHIPS32_OUT
        |-> !DOUBLE_RATE_OUT && BITS_PER_CODE_OUT == 2'h1)
        else $error("double rate active with 64-chip codes");

    a_double_split: assert property (
        DOUBLE_RATE_OUT
        |-> CODE_A_OUT == $past(PN_CODE_IN[31:0])
            && CODE_B_OUT == $past(PN_CODE_IN[63:32]))
        else $error("double rate code halves wrong");

    a_normal_rate: assert property (
        CHIPS32_OUT && !DOUBLE_RATE_OUT |-> RATE_X10_OUT == 10'h140)
        else $error("normal 32-chip rate wrong");

    a_sample_select: assert property (
        s_write(8'h05) |-> ##2 SAMPLE12_OUT)
        else $error("12x sampling not applied after write");

    a_sample_gated: assert property (
        SAMPLE12_OUT |-> CHIPS32_OUT && !DOUBLE_RATE_OUT)
        else $error("12x sampling outside 32-chip normal rate");

    a_half_select: assert property (
        CHIPS32_OUT && !DOUBLE_RATE_OUT && $past(CODE_HALF_SEL_IN)
        |-> CODE_A_OUT == $past(PN_CODE_IN[63:32])
            && CODE_B_OUT == $past(PN_CODE_IN[31:0]))
        else $error("upper code half not selected");

    a_read_back: assert property (
        s_write(8'h07) ##1 !WR_STB_IN ##1 (RD_STB_IN && hit && !WR_STB_IN)
        |=> RD_VALID_OUT && RDATA_OUT == 8'h07)
        else $error("read does not return written fields");

    a_read_pulse: assert property (
        s_read |=> RD_VALID_OUT)
        else $error("read of the register not answered");

    a_read_refused: assert property (
        !(RD_STB_IN && hit) |=> !RD_VALID_OUT)
        else $error("read answer without a read of the register");

    a_read_source: assert property (
        RD_VALID_OUT |-> $past(RD_STB_IN) && $past(hit))
        else $error("read answer not caused by a read hit");

    a_reserved_zero: assert property (
        RD_VALID_OUT |-> RDATA_OUT[7:bcr_pkg::RESERVED_LSB] == '0)
        else $error("reserved bits do not read as zero");

    a_rdata_holds: assert property (
        !$past(RST_IN) && !$past(RD_STB_IN) |-> $stable(RDATA_OUT))
        else $error("read data changed without a read");

    a_bits_double: assert property (
        DOUBLE_RATE_OUT |-> BITS_PER_CODE_OUT == 2'h2)
        else $error("double rate without two bits per code");

    a_bits_normal: assert property (
        !$past(RST_IN) && !DOUBLE_RATE_OUT |-> BITS_PER_CODE_OUT == 2'h1)
        else $error("normal rate without one bit per code");

    a_rate_double: assert property (
        DOUBLE_RATE_OUT |-> RATE_X10_OUT == bcr_pkg::RATE_DOUBLE_X10)
        else $error("double rate throughput wrong");

    a_rate_wide: assert property (
        !$past(RST_IN) && !CHIPS32_OUT
        |-> RATE_X10_OUT == bcr_pkg::RATE_CHIPS64_X10)
        else $error("64-chip throughput wrong");

    a_double_gated: assert property (
        DOUBLE_RATE_OUT |-> CHIPS32_OUT)
        else $error("double rate without 32-chip codes");

    a_normal_split: assert property (
        CHIPS32_OUT && !DOUBLE_RATE_OUT && !$past(CODE_HALF_SEL_IN)
        |-> CODE_A_OUT == $past(PN_CODE_IN[31:0])
            && CODE_B_OUT == $past(PN_CODE_IN[63:32]))
        else $error("lower code half not selected");

    a_wide_split: assert property (
        !$past(RST_IN) && !CHIPS32_OUT
        |-> CODE_A_OUT == $past(PN_CODE_IN[31:0])
            && CODE_B_OUT == $past(PN_CODE_IN[63:32]))
        else $error("64-chip code words wrong");

    a_mode_hold: assert property (
        !$past(RST_IN) && !($past(WR_STB_IN, 2) && $past(hit, 2))
        |-> $stable(CHIPS32_OUT) && $stable(DOUBLE_RATE_OUT)
            && $stable(SAMPLE12_OUT))
        else $error("mode changed without a register write");

    a_width_wide: assert property (
        s_write(8'h00) |-> ##2 !CHIPS32_OUT)
        else $error("64-chip width not applied after write");

    a_sample_wide: assert property (
        s_write(8'h01) |-> ##2 (!CHIPS32_OUT && !SAMPLE12_OUT))
        else $error("12x sampling applied with 64-chip codes");

    a_rate_no_effect: assert property (
        s_write(8'h02) |-> ##2 !DOUBLE_RATE_OUT)
        else $error("double rate applied with 64-chip codes");

    a_both_wide: assert property (
        s_write(8'h03) |-> ##2 (!DOUBLE_RATE_OUT && !SAMPLE12_OUT))
        else $error("rate or sampling applied with 64-chip codes");

    a_sample_low: assert property (
        s_write(8'h04) |-> ##2 (!SAMPLE12_OUT && !DOUBLE_RATE_OUT))
        else $error("6x sampling not applied after write");

    a_sample_ignored: assert property (
        s_write(8'h07) |-> ##2 (DOUBLE_RATE_OUT && !SAMPLE12_OUT))
        else $error("12x sampling applied in double rate");
endmodule : bcr_rate_cfg
`default_nettype wire

// >>> dv/bcr_host_model.sv
// Host model that drives the decoded register strobe port.
`timescale 1ns/10ps
`default_nettype none
module bcr_host_model (
    input wire logic clk_in,
    output logic [7:0] addr_out,
    output logic wr_out,
    output logic [7:0] wdata_out,
    output logic rd_out
);
    initial begin
        addr_out = 8'h00;
        wr_out = 1'b0;
        wdata_out = 8'h00;
        rd_out = 1'b0;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        wdata_out = d & 8'h07;
        wr_out = 1'b1;
        @(negedge clk_in);
        wr_out = 1'b0;
        wdata_out = ~wdata_out;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        @(negedge clk_in);
        addr_out = a;
        rd_out = 1'b1;
        @(negedge clk_in);
        rd_out = 1'b0;
    endtask : rd_reg
endmodule : bcr_host_model
`default_nettype wire

// >>> dv/test_bcr_rate_cfg.sv
// Self-checking bench for the chip rate configuration register.
`timescale 1ns/10ps
`default_nettype none
module test_bcr_rate_cfg;
    logic clk;
    logic rst;
    logic half;
    logic [63:0] pn;
    logic [7:0] addr, wdata, rdata, v;
    logic wr, rd, rd_valid, c32, dbl, s12;
    logic [1:0] bpc;
    logic [9:0] rate;
    logic [31:0] ca, cb;
    logic [7:0] exp_q[$];
    integer seed = 76;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    bcr_rate_cfg bcr_rate_cfg_i (.SYS_CLK_IN(clk), .RST_IN(rst),
        .ADDR_IN(addr), .WR_STB_IN(wr), .WDATA_IN(wdata), .RD_STB_IN(rd),
        .CODE_HALF_SEL_IN(half), .PN_CODE_IN(pn), .RDATA_OUT(rdata),
        .RD_VALID_OUT(rd_valid), .CHIPS32_OUT(c32), .DOUBLE_RATE_OUT(dbl),
        .SAMPLE12_OUT(s12), .BITS_PER_CODE_OUT(bpc), .RATE_X10_OUT(rate),
        .CODE_A_OUT(ca), .CODE_B_OUT(cb));
    bcr_host_model bcr_host_model_i (.clk_in(clk), .addr_out(addr),
        .wr_out(wr), .wdata_out(wdata), .rd_out(rd));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic mode_check(input logic [7:0] x);
        logic c, d, sw;
        logic [9:0] r;
        c = x[2];
        d = c & x[1];
        sw = c & ~d & half;
        r = c ? bcr_pkg::RATE_NORMAL32_X10 : bcr_pkg::RATE_CHIPS64_X10;
        chk(c32, c);
        chk(dbl, d);
        chk(s12, c & ~x[1] & x[0]);
        chk(bpc, d ? 2'h2 : 2'h1);
        chk(rate, d ? bcr_pkg::RATE_DOUBLE_X10 : r);
        chk(ca, sw ? pn[63:32] : pn[31:0]);
        chk(cb, sw ? pn[31:0] : pn[63:32]);
    endtask : mode_check
    always @(negedge clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("BAD %0t unexpected read answer", $time);
            end else begin
                chk(rdata, exp_q.pop_front());
            end
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        rst = 1'b1;
        half = 1'b0;
        pn = 64'h0;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        exp_q.push_back(8'h00);
        bcr_host_model_i.rd_reg(8'h04);
        bcr_host_model_i.wr_reg(8'h04, 8'h07);
        exp_q.push_back(8'h07);
        bcr_host_model_i.rd_reg(8'h04);
        // A write to another address must leave the fields alone.
        bcr_host_model_i.wr_reg(8'h05, 8'h00);
        exp_q.push_back(8'h07);
        bcr_host_model_i.rd_reg(8'h04);
        for (int i = 0; i < 16; i++) begin
            pn = {$random(seed), $random(seed)};
            half = $random(seed);
            v = $random(seed);
            v[2:0] = i[2:0];
            bcr_host_model_i.wr_reg(8'h04, v);
            repeat (2) @(negedge clk);
            mode_check(v);
            exp_q.push_back({5'h00, v[2:0]});
            bcr_host_model_i.rd_reg(8'h04);
        end
        bcr_host_model_i.rd_reg(8'h05);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        exp_q.push_back(8'h00);
        bcr_host_model_i.rd_reg(8'h04);
        repeat (2) @(negedge clk);
        mode_check(8'h00);
        chk(exp_q.size(), 0);
        tally_and_finish();
    end
endmodule : test_bcr_rate_cfg
`default_nettype wire
